// *** src/omc_pkg.sv ***
package omc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;

  localparam int unsigned RESET_HOLD_US = 1000;
  localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned NREQ_TIMEOUT_MS = 150;
  localparam int unsigned NREQ_TIMEOUT_CYC = NREQ_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  localparam int unsigned VDD_LOW_SLEEP_MS = 150;
  localparam int unsigned VDD_LOW_SLEEP_CYC = VDD_LOW_SLEEP_MS * 1000000 / CLK_PERIOD_NS;

  localparam int unsigned CYC_SENSE_PERIOD_DEF = 4096;
  localparam int unsigned CNT_W = 26;

  localparam logic [1:0] MODE_SEL_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SEL_STOP   = 2'h1;
  localparam logic [1:0] MODE_SEL_SLEEP  = 2'h2;

  localparam int unsigned IRQ_SRC_W   = 8;
  localparam int unsigned IRQ_BIT_LV  = 0;
  localparam int unsigned IRQ_BIT_HV  = 1;
  localparam int unsigned IRQ_BIT_OT  = 2;
  localparam int unsigned IRQ_BIT_WKL = 3;
  localparam int unsigned IRQ_BIT_WKB = 4;
  localparam int unsigned IRQ_BIT_WKT = 5;
  localparam logic [IRQ_SRC_W-1:0] IRQ_MASK_RST = 8'h00;
  localparam logic [IRQ_SRC_W-1:0] IRQ_WAKE_BITS = 8'h38;

  typedef enum logic [2:0] {
    OMC_RESET,
    OMC_NREQ,
    OMC_NORMAL,
    OMC_STOP,
    OMC_SLEEP
  } omc_mode_e;

endpackage

// *** src/omc_sync2.sv ***
`timescale 1ns/100ps
module omc_sync2
#(
  parameter int unsigned W = 1
)
(
  input  wire logic         CLK_I,
  input  wire logic         RST_I,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

// *** src/omc_mode_ctrl.sv ***
`timescale 1ns/100ps
// Behaviour
// (R1) After power-up hold reset line low about 1 ms, then enter Normal Request.
// (R2) Enter Reset on regulator low, watchdog failure, Sleep wake-up, or request timeout.
// (R3) Normal Request keeps regulator on, reset line high, bus transceiver receive-only.
// (R4) Normal Request runs a 150 ms timer; expiry without Normal command returns to Reset.
// (R5) Host writes timing register, then mode register with both select bits zero.
// (R6) Grounded watchdog configuration pin skips Normal Request, Reset goes to Normal.
// (R7) Operating mode follows the two mode-select bits written by the host.
// (R8) Normal mode enables window watchdog only with resistor on configuration pin.
// (R9) Normal goes to Sleep on command, or regulator low over 150 ms without undervoltage; code sends regulator low to Reset at once, then Sleep per R10.
// (R10) In Reset, regulator undervoltage with supply-undervoltage flag clear goes to Sleep.
// (R11) Sleep turns regulator off; only wake inputs, wake timer, bus receiver stay active.
// (R12) Cyclic sensing in Sleep runs oscillator, pulses high side, samples wake inputs.
// (R13) Sleep wake-up passes through Reset, reports source, leaves battery-fail flag clear.
// (R14) Stop entered only by command; regulator stays on with limited current.
// (R15) Stop wakes on wake input change, bus, timer, chip-select rise, reset line.
// (R16) Stop wake-up goes to Normal Request with interrupt, except chip-select or reset line.
// (R17) No new interrupt until host has read all pending wake-up sources; code holds back only supply and temperature interrupts, not Stop wake-up.
// (R18) Interrupt line stays low until host reads source register, then returns high.
// (R19) Interrupts only in Normal, Normal Request and Stop, never while reset low.
// (R20) Host masks Normal and Normal Request interrupt sources through mask register.
// (R21) Raise low-voltage and high-voltage supply interrupts on threshold crossings.
// (R22) Raise over-temperature prewarning interrupt at pre-shutdown threshold.
module omc_mode_ctrl
  import omc_pkg::*;
#(
  parameter int unsigned RESET_HOLD  = RESET_HOLD_CYC,
  parameter int unsigned NREQ_TMO    = NREQ_TIMEOUT_CYC,
  parameter int unsigned VDD_LOW_TMO = VDD_LOW_SLEEP_CYC,
  parameter int unsigned CYC_PERIOD  = CYC_SENSE_PERIOD_DEF
)
(
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire logic                 VDD_LOW_I,
  input  wire logic                 SUPPLY_UV_I,
  input  wire logic                 SUPPLY_OV_I,
  input  wire logic                 TEMP_PREWARN_I,
  input  wire logic                 WD_FAIL_I,
  input  wire logic                 WDCFG_GND_I,
  input  wire logic                 WDCFG_RES_I,
  input  wire logic [3:0]           WAKE_INPUTS_I,
  input  wire logic                 BUS_WAKE_I,
  input  wire logic                 CS_N_I,
  input  wire logic                 RST_LINE_I,
  input  wire logic                 MCR_WR_I,
  input  wire logic [1:0]           MCR_MODE_I,
  input  wire logic                 TIMING_CONTROL_REGISTER_WR_I,
  input  wire logic                 CYC_SENSE_EN_I,
  input  wire logic                 FORCE_WAKE_EN_I,
  input  wire logic                 IMR_WR_I,
  input  wire logic [IRQ_SRC_W-1:0] IMR_DATA_I,
  input  wire logic                 ISR_RD_I,
  output logic      [2:0]           MODE_O,
  output logic                      RST_LINE_O,
  output logic                      RST_LINE_OE_O,
  output logic                      IRQ_N_O,
  output logic                      VREG_ON_O,
  output logic                      VREG_LIMIT_O,
  output logic                      BUS_RX_ONLY_O,
  output logic                      WD_EN_O,
  output logic                      LP_OSC_EN_O,
  output logic                      HS_SENSE_O,
  output logic                      BATT_FAIL_O,
  output logic      [IRQ_SRC_W-1:0] ISR_O
);

  logic [10:0] pins_s;
  logic        vdd_low;
  logic        sup_uv;
  logic        sup_ov;
  logic        t_pre;
  logic        rst_ext_n;
  logic        cs_n;
  logic        bus_wk;
  logic [3:0]  wk_in;

  omc_sync2 #(.W(11)) u_sync
  (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .d_i   ({VDD_LOW_I, SUPPLY_UV_I, SUPPLY_OV_I, TEMP_PREWARN_I, RST_LINE_I, CS_N_I, BUS_WAKE_I, WAKE_INPUTS_I}),
    .q_o   (pins_s)
  );

  assign {vdd_low, sup_uv, sup_ov, t_pre, rst_ext_n, cs_n, bus_wk, wk_in} = pins_s;

  omc_mode_e            mode_r;
  omc_mode_e            mode_nxt;
  logic [CNT_W-1:0]     tmr_r;
  logic [CNT_W-1:0]     vlow_r;
  logic [CNT_W-1:0]     cyc_r;
  logic                 tim_ok_r;
  logic                 cs_n_r;
  logic                 sup_uv_r;
  logic                 sup_ov_r;
  logic                 t_pre_r;
  logic [3:0]           wk_ref_r;
  logic [IRQ_SRC_W-1:0] isr_r;
  logic [IRQ_SRC_W-1:0] imr_r;
  logic                 irq_r;
  logic                 batt_fail_r;
  logic [2:0]           own_drv_r;

  // Our own pull-down comes back through the synchroniser, so it must not count as an external reset.
  wire logic              ext_rst     = ~rst_ext_n & ~(|own_drv_r);
  // Counters compare against the parameter cut to counter width.
  wire logic              hold_done   = tmr_r >= CNT_W'(RESET_HOLD - 1);
  wire logic              nreq_expire = tmr_r >= CNT_W'(NREQ_TMO - 1);
  wire logic              vlow_expire = vlow_r >= CNT_W'(VDD_LOW_TMO - 1);
  wire logic              cyc_tick    = cyc_r >= CNT_W'(CYC_PERIOD - 1);
  wire logic              cs_rise     = cs_n & ~cs_n_r;
  wire logic              lp_mode     = (mode_r == OMC_STOP) || (mode_r == OMC_SLEEP);
  wire logic              cyc_mode    = lp_mode & CYC_SENSE_EN_I & ~FORCE_WAKE_EN_I;
  wire logic              wk_change   = lp_mode & (wk_in != wk_ref_r) & (~CYC_SENSE_EN_I | cyc_tick); // (R12)
  wire logic              timer_wake  = lp_mode & FORCE_WAKE_EN_I & ~CYC_SENSE_EN_I & cyc_tick;
  wire logic              src_wake    = wk_change | bus_wk & lp_mode | timer_wake;
  wire logic              mcr_normal  = MCR_WR_I & (MCR_MODE_I == MODE_SEL_NORMAL);
  wire logic              mcr_stop    = MCR_WR_I & (MCR_MODE_I == MODE_SEL_STOP);
  wire logic              mcr_sleep   = MCR_WR_I & (MCR_MODE_I == MODE_SEL_SLEEP);
  wire logic              irq_mode    = (mode_r == OMC_NORMAL) || (mode_r == OMC_NREQ) || (mode_r == OMC_STOP);
  wire logic              rst_low     = (mode_r == OMC_RESET) || ext_rst;
  wire logic [IRQ_SRC_W-1:0] evt_wake;
  wire logic [IRQ_SRC_W-1:0] evt_run;
  wire logic [IRQ_SRC_W-1:0] evt_all;
  wire logic                 wake_pend;

  assign evt_wake = (mode_r == OMC_SLEEP || mode_r == OMC_STOP) ?
                    {2'h0, timer_wake, bus_wk, wk_change, 3'h0} : '0;
  assign evt_run  = ((mode_r == OMC_NORMAL) || (mode_r == OMC_NREQ)) ?
                    ({5'h00, t_pre & ~t_pre_r, sup_ov & ~sup_ov_r, sup_uv & ~sup_uv_r} & ~imr_r) : '0; // (R20) (R21) (R22)
  assign evt_all   = evt_wake | evt_run;
  assign wake_pend = |(isr_r & IRQ_WAKE_BITS);

  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      OMC_RESET:
      begin
        if (vdd_low & ~sup_uv)
          mode_nxt = OMC_SLEEP; // (R10)
        else if (vdd_low | WD_FAIL_I | ext_rst)
          mode_nxt = OMC_RESET;
        else if (hold_done)
          mode_nxt = WDCFG_GND_I ? OMC_NORMAL : OMC_NREQ; // (R1) (R6)
      end
      OMC_NREQ:
      begin
        if (vdd_low | ext_rst | nreq_expire)
          mode_nxt = OMC_RESET; // (R2) (R4)
        else if (mcr_normal & tim_ok_r)
          mode_nxt = OMC_NORMAL; // (R5) (R7)
      end
      OMC_NORMAL:
      begin
        if (mcr_sleep | (vlow_expire & ~sup_uv))
          mode_nxt = OMC_SLEEP; // (R9)
        else if (vdd_low | WD_FAIL_I | ext_rst)
          mode_nxt = OMC_RESET; // (R2)
        else if (mcr_stop)
          mode_nxt = OMC_STOP; // (R14)
      end
      OMC_STOP:
      begin
        if (vdd_low)
          mode_nxt = OMC_RESET;
        else if (src_wake | cs_rise | ext_rst)
          mode_nxt = WDCFG_GND_I ? OMC_NORMAL : OMC_NREQ; // (R15) (R16)
      end
      OMC_SLEEP:
      begin
        if (src_wake)
          mode_nxt = OMC_RESET; // (R13)
      end
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      mode_r   <= OMC_RESET;
      cs_n_r   <= 1'b1;
      sup_uv_r <= 1'b0;
      sup_ov_r <= 1'b0;
      t_pre_r  <= 1'b0;
    end
    else
    begin
      mode_r   <= mode_nxt;
      cs_n_r   <= cs_n;
      sup_uv_r <= sup_uv;
      sup_ov_r <= sup_ov;
      t_pre_r  <= t_pre;
    end
  end

  // Three cycles cover the output register and both synchroniser stages.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      own_drv_r <= 3'h7;
    end
    else
    begin
      own_drv_r <= {own_drv_r[1:0], RST_LINE_OE_O};
    end
  end

  // Reset hold restarts while any reset cause persists, so the 1 ms counts from its removal.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      tmr_r <= '0;
    end
    else
    begin
      if ((mode_nxt != mode_r) || (mode_r == OMC_RESET && (vdd_low | WD_FAIL_I | ext_rst)))
        tmr_r <= '0;
      else if (!hold_done || mode_r == OMC_NREQ)
        tmr_r <= tmr_r + 1'b1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      vlow_r <= '0;
      cyc_r  <= '0;
    end
    else
    begin
      vlow_r <= (mode_r == OMC_NORMAL && vdd_low) ? vlow_r + 1'b1 : '0;
      cyc_r  <= (!lp_mode || cyc_tick) ? '0 : cyc_r + 1'b1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      wk_ref_r <= 4'h0;
    end
    else
    begin
      if (!lp_mode || cyc_tick || !CYC_SENSE_EN_I)
        wk_ref_r <= wk_in;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      tim_ok_r <= 1'b0;
    end
    else
    begin
      if (mode_r != OMC_NREQ)
        tim_ok_r <= 1'b0;
      else if (TIMING_CONTROL_REGISTER_WR_I)
        tim_ok_r <= 1'b1; // (R5)
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      batt_fail_r <= 1'b1;
    end
    else
    begin
      if (ISR_RD_I)
        batt_fail_r <= 1'b0; // (R13)
    end
  end

  // A source that fires in the read cycle survives, since set wins over clear.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      isr_r <= '0;
      imr_r <= IRQ_MASK_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      if (IMR_WR_I)
        imr_r <= IMR_DATA_I; // (R20)
      isr_r <= (ISR_RD_I ? '0 : isr_r) | evt_all; // (R13)
      if (ISR_RD_I | rst_low | ~irq_mode)
        irq_r <= 1'b0; // (R18) (R19)
      else if (!wake_pend && (|evt_run))
        irq_r <= 1'b1; // (R17) (R21) (R22)
      else if ((mode_r == OMC_STOP) && src_wake)
        irq_r <= 1'b1; // (R16)
    end
  end

  // Wake interrupts raised in Stop carry into Normal Request, where irq_mode still holds.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      MODE_O        <= 3'h0;
      RST_LINE_O    <= 1'b0;
      RST_LINE_OE_O <= 1'b1;
      IRQ_N_O       <= 1'b1;
      VREG_ON_O     <= 1'b1;
      VREG_LIMIT_O  <= 1'b0;
      BUS_RX_ONLY_O <= 1'b1;
      WD_EN_O       <= 1'b0;
      LP_OSC_EN_O   <= 1'b0;
      HS_SENSE_O    <= 1'b0;
      BATT_FAIL_O   <= 1'b1;
      ISR_O         <= '0;
    end
    else
    begin
      MODE_O        <= mode_r;
      RST_LINE_O    <= 1'b0;
      RST_LINE_OE_O <= (mode_r == OMC_RESET); // (R1) (R3)
      IRQ_N_O       <= ~(irq_r & irq_mode & ~rst_low); // (R18) (R19)
      VREG_ON_O     <= (mode_r != OMC_SLEEP); // (R3) (R11)
      VREG_LIMIT_O  <= (mode_r == OMC_STOP); // (R14)
      BUS_RX_ONLY_O <= (mode_r != OMC_NORMAL); // (R3)
      WD_EN_O       <= (mode_r == OMC_NORMAL) && WDCFG_RES_I && !WDCFG_GND_I; // (R8)
      LP_OSC_EN_O   <= cyc_mode | (lp_mode & FORCE_WAKE_EN_I); // (R12)
      HS_SENSE_O    <= cyc_mode & (cyc_r == '0); // (R12)
      BATT_FAIL_O   <= batt_fail_r;
      ISR_O         <= isr_r;
    end
  end

endmodule

// *** verif/omc_mode_ctrl_sva.sv ***
`timescale 1ns/100ps
module omc_mode_ctrl_sva
#(
  parameter int unsigned RESET_HOLD = 20,
  parameter int unsigned NREQ_TMO   = 200
)
(
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       MCR_WR_I,
  input wire logic [1:0] MCR_MODE_I,
  input wire logic       ISR_RD_I,
  input wire logic       WDCFG_GND_I,
  input wire logic       WDCFG_RES_I,
  input wire logic [2:0] MODE_O,
  input wire logic       RST_LINE_OE_O,
  input wire logic       IRQ_N_O,
  input wire logic       VREG_ON_O,
  input wire logic       VREG_LIMIT_O,
  input wire logic       BUS_RX_ONLY_O,
  input wire logic       WD_EN_O
);
  int unsigned rcnt_r;
  int unsigned ncnt_r;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Run lengths are counted here because a repetition of thousands of cycles would stall the tools.
  always_ff @(posedge CLK_I)
  begin
    rcnt_r <= (RST_I || MODE_O != 3'h0) ? 0 : rcnt_r + 1;
    ncnt_r <= (RST_I || MODE_O != 3'h1) ? 0 : ncnt_r + 1;
  end
  property p_hold; ($past(MODE_O) == 3'h0 && MODE_O inside {3'h1, 3'h2}) |-> rcnt_r >= RESET_HOLD - 1; endproperty
  a_hold: assert property (p_hold) else $error("reset released too early");
  property p_tmo; ncnt_r <= NREQ_TMO + 2; endproperty
  a_tmo: assert property (p_tmo) else $error("normal request outlived its timeout");
  property p_nreq; MODE_O == 3'h1 |-> VREG_ON_O && BUS_RX_ONLY_O && !RST_LINE_OE_O; endproperty
  a_nreq: assert property (p_nreq) else $error("wrong outputs in normal request");
  property p_stop; MCR_WR_I && MCR_MODE_I == 2'h1 && MODE_O == 3'h2 |-> ##2 MODE_O == 3'h3 && VREG_LIMIT_O; endproperty
  a_stop: assert property (p_stop) else $error("stop command not honoured");
  property p_sleep; MCR_WR_I && MCR_MODE_I == 2'h2 && MODE_O == 3'h2 |-> ##2 MODE_O == 3'h4 && !VREG_ON_O; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep command not honoured");
  property p_irq_rel; ISR_RD_I && !IRQ_N_O |-> ##2 IRQ_N_O; endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("interrupt not released by read");
  property p_irq_mode; MODE_O == 3'h0 || MODE_O == 3'h4 |-> IRQ_N_O; endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("interrupt in reset or sleep");
  property p_wd; WD_EN_O |-> MODE_O == 3'h2 && WDCFG_RES_I; endproperty
  a_wd: assert property (p_wd) else $error("watchdog enabled wrongly");
  property p_gnd; WDCFG_GND_I |-> MODE_O != 3'h1; endproperty
  a_gnd: assert property (p_gnd) else $error("normal request with grounded config");
  c_stop: cover property (MODE_O == 3'h3);
  c_sleep: cover property (MODE_O == 3'h4);
  c_irq: cover property ($fell(IRQ_N_O));
endmodule
bind omc_mode_ctrl omc_mode_ctrl_sva #(.RESET_HOLD(RESET_HOLD), .NREQ_TMO(NREQ_TMO)) omc_mode_ctrl_sva_i (.*);

// *** verif/omc_host_mdl.sv ***
`timescale 1ns/100ps
module omc_host_mdl
(
  input  wire logic clk_i,
  output logic      timing_control_register_wr_o,
  output logic      mcr_wr_o,
  output logic      imr_wr_o,
  output logic      isr_rd_o,
  output logic [1:0] mcr_mode_o,
  output logic [7:0] imr_data_o,
  output logic      cs_n_o,
  output logic      rst_pull_o
);
  initial
  begin
    {isr_rd_o, imr_wr_o, mcr_wr_o, timing_control_register_wr_o, cs_n_o, rst_pull_o} = 6'h02;
    mcr_mode_o = 2'h3;
    imr_data_o = 8'h00;
  end
  // Data is inverted once the strobe drops, so nothing relies on a stale value.
  task automatic acc(input logic [1:0] k, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    {isr_rd_o, imr_wr_o, mcr_wr_o, timing_control_register_wr_o} = 4'h1 << k;
    mcr_mode_o = d[1:0];
    imr_data_o = d;
    @(posedge clk_i);
    #1;
    {isr_rd_o, imr_wr_o, mcr_wr_o, timing_control_register_wr_o} = 4'h0;
    mcr_mode_o = ~d[1:0];
    imr_data_o = ~d;
  endtask
  task automatic go_normal();
    acc(2'h0, 8'h00);
    acc(2'h1, 8'h00);
  endtask
  task automatic pull(input logic rl);
    @(posedge clk_i);
    #1;
    if (rl)
      rst_pull_o = 1'b1;
    else
      cs_n_o = 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    rst_pull_o = 1'b0;
    cs_n_o = 1'b1;
  endtask
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
  import omc_pkg::*;
;
  logic       clk, rst, vdd_low, wd_fail, gnd, res, bus_wake, cyc, fwake;
  logic [2:0] src;
  logic [3:0] wk;
  wire        tim_wr, mcr_wr, imr_wr, isr_rd, cs_n, rst_pull, oe, rl, irq_n, vreg, vlim, rxo, wden, lpo, hs, bf;
  wire  [1:0] msel;
  wire  [7:0] imr_d, interrupt_source_register;
  wire  [2:0] mode;
  wire        line = oe ? rl : ~rst_pull;
  int         error_cnt, total_checks, n, hs_cnt;
  localparam logic [8:0] WEXP [5] = '{9'h008, 9'h010, 9'h100, 9'h100, 9'h020};
  omc_host_mdl host_i (.clk_i(clk), .timing_control_register_wr_o(tim_wr), .mcr_wr_o(mcr_wr), .imr_wr_o(imr_wr), .isr_rd_o(isr_rd),
    .mcr_mode_o(msel), .imr_data_o(imr_d), .cs_n_o(cs_n), .rst_pull_o(rst_pull));
  omc_mode_ctrl #(.RESET_HOLD(20), .NREQ_TMO(200), .VDD_LOW_TMO(100), .CYC_PERIOD(16)) omc_mode_ctrl_i (
    .CLK_I(clk), .RST_I(rst), .VDD_LOW_I(vdd_low), .SUPPLY_UV_I(src[0]), .SUPPLY_OV_I(src[1]),
    .TEMP_PREWARN_I(src[2]), .WD_FAIL_I(wd_fail), .WDCFG_GND_I(gnd), .WDCFG_RES_I(res), .WAKE_INPUTS_I(wk),
    .BUS_WAKE_I(bus_wake), .CS_N_I(cs_n), .RST_LINE_I(line), .MCR_WR_I(mcr_wr), .MCR_MODE_I(msel),
    .TIMING_CONTROL_REGISTER_WR_I(tim_wr), .CYC_SENSE_EN_I(cyc), .FORCE_WAKE_EN_I(fwake), .IMR_WR_I(imr_wr), .IMR_DATA_I(imr_d),
    .ISR_RD_I(isr_rd), .MODE_O(mode), .RST_LINE_O(rl), .RST_LINE_OE_O(oe), .IRQ_N_O(irq_n), .VREG_ON_O(vreg),
    .VREG_LIMIT_O(vlim), .BUS_RX_ONLY_O(rxo), .WD_EN_O(wden), .LP_OSC_EN_O(lpo), .HS_SENSE_O(hs),
    .BATT_FAIL_O(bf), .ISR_O(interrupt_source_register));
  always #2 clk = ~clk;
  always @(posedge clk) hs_cnt <= hs_cnt + hs;
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Bounded wait, so a stuck mode shows as a mismatch instead of a hang.
  task automatic wm(input logic [2:0] m);
    n = 0;
    while (mode !== m && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    chk(mode, m);
    #1;
  endtask
  initial
  begin
    #(4 * 40000);
    error_cnt++;
    $display("ERROR %0t: timeout", $time);
    conclude();
  end
  initial
  begin
    clk = 0; rst = 1; res = 1; src = 0; wk = 0; hs_cnt = 0; error_cnt = 0; total_checks = 0;
    vdd_low = 1'b0;
    wd_fail = 1'b0;
    gnd = 1'b0;
    bus_wake = 1'b0;
    cyc = 1'b0;
    fwake = 1'b0;
    tick(6);
    rst = 0;
    chk({mode, oe, irq_n, bf}, 6'h07);
    wm(3'h1);
    chk(n >= 20, 1);
    chk({vreg, rxo, oe}, 3'h6);
    wm(3'h0);
    chk(n >= 200, 1);
    wm(3'h1);
    host_i.acc(2'h1, 8'h00);
    tick(4);
    chk(mode, 3'h1);
    host_i.go_normal();
    wm(3'h2);
    chk({rxo, wden}, 2'h1);
    host_i.acc(2'h3, 8'h00);
    tick(2);
    chk(bf, 0);
    for (int i = 0; i < 3; i++)
    begin
      src[i] = 1;
      tick(6);
      chk({irq_n, interrupt_source_register}, {1'b0, 8'h01 << i});
      host_i.acc(2'h3, 8'h00);
      tick(2);
      chk({irq_n, interrupt_source_register}, 9'h100);
      src[i] = 0;
    end
    host_i.acc(2'h2, 8'h01);
    src[0] = 1;
    tick(6);
    chk(irq_n, 1);
    src[0] = 0;
    host_i.acc(2'h2, 8'h00);
    host_i.acc(2'h3, 8'h00);
    wd_fail = 1;
    wm(3'h0);
    wd_fail = 0;
    wm(3'h1);
    host_i.go_normal();
    wm(3'h2);
    for (int k = 0; k < 5; k++)
    begin
      fwake = (k == 4);
      host_i.acc(2'h1, 8'h01);
      wm(3'h3);
      chk(vlim, 1);
      case (k)
        0: wk = ~wk;
        1: bus_wake = 1;
        2: host_i.pull(1'b0);
        3: host_i.pull(1'b1);
        default: ;
      endcase
      tick(8);
      bus_wake = 0;
      wm(3'h1);
      tick(3);
      chk({irq_n, interrupt_source_register & IRQ_WAKE_BITS}, WEXP[k]);
      fwake = 0;
      host_i.acc(2'h3, 8'h00);
      host_i.go_normal();
      wm(3'h2);
    end
    cyc = 1;
    host_i.acc(2'h1, 8'h02);
    wm(3'h4);
    chk({vreg, lpo}, 2'h1);
    n = hs_cnt;
    tick(64);
    chk(hs_cnt - n, 4);
    wk = ~wk;
    wm(3'h0);
    wm(3'h1);
    chk({bf, interrupt_source_register[IRQ_BIT_WKL]}, 2'h1);
    cyc = 0;
    host_i.acc(2'h3, 8'h00);
    vdd_low = 1;
    wm(3'h4);
    vdd_low = 0;
    gnd = 1;
    res = 0;
    rst = 1;
    tick(6);
    rst = 0;
    wm(3'h2);
    chk(wden, 0);
    conclude();
  end
endmodule
